// >>> shared/lcdd_regs.svh
// Behaviour
// - display off drives every segment at non-selection level.
// - base clock derives from clock timer, runs only while its run bit set.
// - frame rate equals base clock over number of time divisions.
// - reset clears display control register to zero.
// - control register holds bias current control and segment/port pin selection.
// - segment-configured pin ignores port output latch.
// - port read of segment-configured pin returns zero.
// - segment-configured pin never gets internal pull-up.
// - 40 display bytes, one per segment, usable as ordinary RAM.
// - display byte bits 7..4 have no storage and read zero.
// - commons selected in fixed repeating order; static drives all four alike.
// - two divisions leave commons 2,3 open; three leave common 3 open.
// - in common n slot, segment selects when its byte bit n is one.
// - bits not scanned in current mode stay free storage.
// - full on voltage only when common and segment both selected.
// - drive polarity alternates so no net DC reaches the panel.
// - each common slot lasts one base clock period; a half phase lasts one whole frame.
// - mode register resets zero; enable, clock select, division mode fields.
// - clock select codes 0..3 divide timer clock by 512,256,128,64.
`ifndef LCDD_REGS_SVH
`define LCDD_REGS_SVH

`define LCDD_MODE_OFS 8'h00
`define LCDD_CTRL_OFS 8'h01
`define LCDD_RAM_BASE 8'h58
`define LCDD_RAM_LAST 8'h7F
`define LCDD_MODE_RST 8'h00
`define LCDD_CTRL_RST 8'h00
`define LCDD_MODE_WMASK 8'hF7
`define LCDD_CTRL_WMASK 8'h1F
`define LCDD_MODE_EN_BIT 7
`define LCDD_MODE_CLK_LSB 4
`define LCDD_MODE_DIV_LSB 0
`define LCDD_CTRL_BIAS_BIT 0
`define LCDD_CTRL_SEG_LSB 1
`define LCDD_MD_4_THIRD 3'h0
`define LCDD_MD_3_THIRD 3'h1
`define LCDD_MD_2_HALF 3'h2
`define LCDD_MD_3_HALF 3'h3
`define LCDD_MD_STATIC 3'h4
`define LCDD_TC_512 9'h1FF
`define LCDD_TC_256 9'h0FF
`define LCDD_TC_128 9'h07F
`define LCDD_TC_64 9'h03F

`endif

// >>> shared/lcdd_pkg.sv
package lcdd_pkg;

  // drive rail index handed to the analog stage
  typedef enum logic [1:0] {
    LCDD_VLC0 = 2'h0,
    LCDD_VLC1 = 2'h1,
    LCDD_VLC2 = 2'h2,
    LCDD_VSS = 2'h3
  } lcdd_level_t;

  typedef enum logic [1:0] {
    LCDD_BIAS_NONE = 2'h0,
    LCDD_BIAS_HALF = 2'h1,
    LCDD_BIAS_THIRD = 2'h2
  } lcdd_bias_t;

endpackage : lcdd_pkg

// >>> rtl/lcdd_ram.sv
`timescale 1ns/1ps
`include "lcdd_regs.svh"
module lcdd_ram
  import lcdd_pkg::*;
#(
  parameter int WORDS = 40
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic hit_in,
  input wire logic [5:0] idx_in,
  input wire logic [3:0] wdata_in,
  input wire logic [7:0] alt_rdata_in,
  input wire logic [1:0] bit_sel_in,
  output logic [7:0] rdata_out,
  output logic [WORDS-1:0] col_out
);

  logic [3:0] mem_q [WORDS];
  logic [7:0] rdata_q;
  logic [WORDS-1:0] col_q;
  wire logic [7:0] ram_rd_w = {4'h0, mem_q[idx_in]};

  // ----------------------------------------
  // storage and column scan
  // ----------------------------------------
  for (genvar i = 0; i < WORDS; i++)
  begin : g_word
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        mem_q[i] <= 4'h0;
        col_q[i] <= 1'b0;
      end
      else
      begin
        if (wr_in && hit_in && idx_in == 6'(i))
          mem_q[i] <= wdata_in;
        col_q[i] <= mem_q[i][bit_sel_in];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_q <= 8'h00;
    else if (rd_in)
      rdata_q <= hit_in ? ram_rd_w : alt_rdata_in;
    else
      rdata_q <= 8'h00;
  end

  assign rdata_out = rdata_q;
  assign col_out = col_q;

endmodule : lcdd_ram

// >>> rtl/lcdd_top.sv
`timescale 1ns/1ps
`include "lcdd_regs.svh"
module lcdd_top
  import lcdd_pkg::*;
#(
  parameter int SEGS = 40,
  parameter int SHARED = 16
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic fw_tick_in,
  input wire logic clock_timer_run_bit_in,
  input wire logic [SHARED-1:0] port_latch_in,
  input wire logic [SHARED-1:0] port_dir_in,
  input wire logic pullup_option_port8_in,
  input wire logic pullup_option_port9_in,
  input wire logic [SHARED-1:0] pin_in,
  output logic [2*SEGS-1:0] seg_level_out,
  output logic [SHARED-1:0] seg_drive_en_out,
  output logic [7:0] com_level_out,
  output logic [3:0] com_oe_out,
  output logic drive_phase_out,
  output logic bias_current_control_out,
  output logic [SHARED-1:0] port_out_out,
  output logic [SHARED-1:0] port_oe_out,
  output logic [SHARED-1:0] pullup_en_out,
  output logic [SHARED-1:0] port_read_out
);

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [7:0] display_mode_reg_q;
  logic [7:0] display_control_reg_q;

  wire logic mode_hit_w = (addr_in == `LCDD_MODE_OFS);
  wire logic ctrl_hit_w = (addr_in == `LCDD_CTRL_OFS);
  wire logic ram_hit_w = (addr_in >= `LCDD_RAM_BASE) && (addr_in <= `LCDD_RAM_LAST);
  wire logic [7:0] ram_off_w = addr_in - `LCDD_RAM_BASE;
  wire logic [5:0] ram_idx_w = ram_off_w[5:0];
  wire logic [7:0] alt_rdata_w = mode_hit_w ? display_mode_reg_q :
                                 ctrl_hit_w ? display_control_reg_q : 8'h00;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      display_mode_reg_q <= `LCDD_MODE_RST;
      display_control_reg_q <= `LCDD_CTRL_RST;
    end
    else if (wr_in)
    begin
      if (mode_hit_w)
        display_mode_reg_q <= wdata_in & `LCDD_MODE_WMASK;
      if (ctrl_hit_w)
        display_control_reg_q <= wdata_in & `LCDD_CTRL_WMASK;
    end
  end

  wire logic display_enable = display_mode_reg_q[`LCDD_MODE_EN_BIT];
  wire logic [2:0] clk_sel_w = display_mode_reg_q[`LCDD_MODE_CLK_LSB +: 3];
  wire logic [2:0] div_mode_w = display_mode_reg_q[`LCDD_MODE_DIV_LSB +: 3];
  wire logic [3:0] seg_grp_w = display_control_reg_q[`LCDD_CTRL_SEG_LSB +: 4];
  // shared pins switch in groups of four, lowest group is segments 24..27
  wire logic [SHARED-1:0] seg_mask_w = {{4{seg_grp_w[3]}}, {4{seg_grp_w[2]}},
                                        {4{seg_grp_w[1]}}, {4{seg_grp_w[0]}}};

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic [1:0] last_slot_w;
  lcdd_bias_t bias_w;

  always_comb
  begin
    last_slot_w = 2'h3;
    bias_w = LCDD_BIAS_THIRD;
    case (div_mode_w)
      `LCDD_MD_4_THIRD:
      begin
        last_slot_w = 2'h3;
        bias_w = LCDD_BIAS_THIRD;
      end
      `LCDD_MD_3_THIRD:
      begin
        last_slot_w = 2'h2;
        bias_w = LCDD_BIAS_THIRD;
      end
      `LCDD_MD_2_HALF:
      begin
        last_slot_w = 2'h1;
        bias_w = LCDD_BIAS_HALF;
      end
      `LCDD_MD_3_HALF:
      begin
        last_slot_w = 2'h2;
        bias_w = LCDD_BIAS_HALF;
      end
      `LCDD_MD_STATIC:
      begin
        last_slot_w = 2'h0;
        bias_w = LCDD_BIAS_NONE;
      end
      default:
      begin
        last_slot_w = 2'h3;
        bias_w = LCDD_BIAS_THIRD;
      end
    endcase
  end

  // ----------------------------------------
  // base clock divider
  // ----------------------------------------
  logic [8:0] fw_cnt_q;
  logic [8:0] term_w;

  always_comb
  begin
    case (clk_sel_w[1:0])
      2'h0: term_w = `LCDD_TC_512;
      2'h1: term_w = `LCDD_TC_256;
      2'h2: term_w = `LCDD_TC_128;
      default: term_w = `LCDD_TC_64;
    endcase
  end

  // a stopped clock timer freezes the scan, as on the real panel
  wire logic fw_step_w = fw_tick_in && clock_timer_run_bit_in;
  wire logic base_tick_w = fw_step_w && (fw_cnt_q >= term_w);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      fw_cnt_q <= 9'h000;
    else if (base_tick_w)
      fw_cnt_q <= 9'h000;
    else if (fw_step_w)
      fw_cnt_q <= fw_cnt_q + 9'h001;
  end

  // ----------------------------------------
  // slot and polarity
  // ----------------------------------------
  logic [1:0] slot_q;
  logic phase_q;
  logic [1:0] slot_dly_q;
  logic phase_dly_q;
  wire logic wrap_w = (slot_q >= last_slot_w);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      slot_q <= 2'h0;
      phase_q <= 1'b0;
    end
    else if (base_tick_w)
    begin
      // polarity flips once per frame; per-slot flipping leaves DC on even duty
      slot_q <= wrap_w ? 2'h0 : slot_q + 2'h1;
      phase_q <= wrap_w ? ~phase_q : phase_q;
    end
  end

  // aligns slot and phase with the column register in the memory
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      slot_dly_q <= 2'h0;
      phase_dly_q <= 1'b0;
    end
    else
    begin
      slot_dly_q <= slot_q;
      phase_dly_q <= phase_q;
    end
  end

  // ----------------------------------------
  // display memory
  // ----------------------------------------
  logic [SEGS-1:0] col_w;

  lcdd_ram #(
    .WORDS(SEGS)
  ) u_ram (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .hit_in(ram_hit_w),
    .idx_in(ram_idx_w),
    .wdata_in(wdata_in[3:0]),
    .alt_rdata_in(alt_rdata_w),
    .bit_sel_in(slot_q),
    .rdata_out(rdata_out),
    .col_out(col_w)
  );

  // ----------------------------------------
  // drive level encoding
  // ----------------------------------------
  function automatic lcdd_level_t seg_code(input logic on, input logic ph,
                                           input lcdd_bias_t b);
    if (on)
      seg_code = ph ? LCDD_VLC0 : LCDD_VSS;
    else if (b == LCDD_BIAS_THIRD)
      seg_code = ph ? LCDD_VLC2 : LCDD_VLC1;
    else
      seg_code = ph ? LCDD_VSS : LCDD_VLC0;
  endfunction : seg_code

  function automatic lcdd_level_t com_code(input logic sel, input logic ph,
                                           input lcdd_bias_t b);
    if (sel)
      com_code = ph ? LCDD_VSS : LCDD_VLC0;
    else if (b == LCDD_BIAS_THIRD)
      com_code = ph ? LCDD_VLC1 : LCDD_VLC2;
    else
      com_code = LCDD_VLC1;
  endfunction : com_code

  logic [2*SEGS-1:0] seg_level_q;
  logic [SEGS-1:0] seg_act_q;
  logic [7:0] com_level_q;
  logic [3:0] com_oe_q;
  logic drive_phase_q;

  wire logic [SEGS-1:0] seg_on_w = display_enable ? col_w : '0;

  for (genvar i = 0; i < SEGS; i++)
  begin : g_seg
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        seg_level_q[2*i +: 2] <= LCDD_VLC0;
        seg_act_q[i] <= 1'b0;
      end
      else
      begin
        seg_level_q[2*i +: 2] <= seg_code(seg_on_w[i], phase_dly_q, bias_w);
        seg_act_q[i] <= seg_on_w[i];
      end
    end
  end

  for (genvar k = 0; k < 4; k++)
  begin : g_com
    wire logic sel_w = (bias_w == LCDD_BIAS_NONE) || (slot_dly_q == 2'(k));
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        com_level_q[2*k +: 2] <= LCDD_VLC0;
        com_oe_q[k] <= 1'b0;
      end
      else
      begin
        com_level_q[2*k +: 2] <= com_code(sel_w, phase_dly_q, bias_w);
        com_oe_q[k] <= (bias_w == LCDD_BIAS_NONE) || (2'(k) <= last_slot_w);
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      drive_phase_q <= 1'b0;
    else
      drive_phase_q <= phase_dly_q;
  end

  // ----------------------------------------
  // shared port pins
  // ----------------------------------------
  logic [SHARED-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [SHARED-1:0] port_out_q, port_oe_q, pullup_q, port_read_q, seg_en_q;
  logic bias_q;
  wire logic [SHARED-1:0] pu_opt_w = {{8{pullup_option_port8_in}},
                                      {8{pullup_option_port9_in}}};

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      // take the new level only once stages two and three agree, else hold
      pin_q <= (pin_q & (pin_s2_q ^ pin_s3_q)) | (pin_s3_q & ~(pin_s2_q ^ pin_s3_q));
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      port_out_q <= '0;
      port_oe_q <= '0;
      pullup_q <= '0;
      port_read_q <= '0;
      seg_en_q <= '0;
      bias_q <= 1'b0;
    end
    else
    begin
      port_out_q <= port_latch_in & ~seg_mask_w;
      port_oe_q <= port_dir_in & ~seg_mask_w;
      pullup_q <= pu_opt_w & ~port_dir_in & ~seg_mask_w;
      port_read_q <= pin_q & ~seg_mask_w;
      seg_en_q <= seg_mask_w;
      bias_q <= display_control_reg_q[`LCDD_CTRL_BIAS_BIT];
    end
  end

  assign seg_level_out = seg_level_q;
  assign seg_drive_en_out = seg_en_q;
  assign com_level_out = com_level_q;
  assign com_oe_out = com_oe_q;
  assign drive_phase_out = drive_phase_q;
  assign bias_current_control_out = bias_q;
  assign port_out_out = port_out_q;
  assign port_oe_out = port_oe_q;
  assign pullup_en_out = pullup_q;
  assign port_read_out = port_read_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_wrap_tick;
    base_tick_w && wrap_w;
  endsequence

  sequence s_off_held;
    !display_enable [*2];
  endsequence

  a_off_nonsel: assert property (s_off_held |=> seg_act_q == '0)
    else $error("segment selected while display off");
  a_ctrl_clear: assert property ($rose(arst_n_in) |-> display_control_reg_q == 8'h00)
    else $error("control register not cleared by reset");
  a_seg_no_port: assert property (##1 (port_oe_q & $past(seg_mask_w)) == '0)
    else $error("segment pin driven as port");
  a_read_zero: assert property (##1 (port_read_q & $past(seg_mask_w)) == '0)
    else $error("segment pin reads nonzero");
  a_pullup_off: assert property (##1 (pullup_q & $past(seg_mask_w)) == '0)
    else $error("pull-up on segment pin");
  a_ram_top_zero: assert property (rd_in && ram_hit_w |=> rdata_out[7:4] == 4'h0)
    else $error("display byte upper bits nonzero");
  a_slot_wrap: assert property (s_wrap_tick |=> slot_q == 2'h0 && phase_q != $past(phase_q))
    else $error("slot did not wrap with polarity flip");
  a_slot_step: assert property (base_tick_w && !wrap_w |=> slot_q == $past(slot_q) + 2'h1)
    else $error("slot did not advance on base tick");
  a_com_open: assert property (div_mode_w == `LCDD_MD_2_HALF [*2] |-> com_oe_q[3:2] == 2'h0)
    else $error("unused common driven");
  a_stop_freeze: assert property (!clock_timer_run_bit_in |=> slot_q == $past(slot_q))
    else $error("scan advanced with clock timer stopped");

endmodule : lcdd_top

// >>> tb/lcdd_panel.sv
`timescale 1ns/1ps
module lcdd_panel
  import lcdd_pkg::*;
(
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic [1:0] seg_level_in,
  input wire logic [7:0] com_level_in,
  input wire logic [3:0] com_oe_in,
  output logic [3:0] lit_out,
  output int dc_out
);
  // ----------------------------------------
  // glass response of one segment column
  // ----------------------------------------
  // only rail pairs at opposite ends give full on voltage
  always @(posedge clk_in)
  begin
    if (clr_in)
    begin
      lit_out <= 4'h0;
      dc_out <= 0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (com_oe_in[k] && ({seg_level_in, com_level_in[2*k +: 2]} == 4'h3 ||
            {seg_level_in, com_level_in[2*k +: 2]} == 4'hC))
          lit_out[k] <= 1'b1;
      end
      // net charge only meaningful where rail codes are linear in voltage
      dc_out <= dc_out + int'(seg_level_in) - int'(com_level_in[1:0]);
    end
  end
endmodule : lcdd_panel

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "lcdd_regs.svh"
module testbench
  import lcdd_pkg::*;
;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b1;
  logic [15:0] pin = 16'hFFFF;
  logic clr = 1'b0;
  logic [7:0] rdata;
  logic [79:0] seg_level;
  logic [15:0] seg_en, port_out, port_oe, pullup_en, port_read;
  logic [7:0] com_level;
  logic [3:0] com_oe, lit;
  logic phase, bias;
  int dc;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int n;

  lcdd_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .fw_tick_in(1'b1),
    .clock_timer_run_bit_in(run), .port_latch_in(16'hFFFF), .port_dir_in(16'h00F3),
    .pullup_option_port8_in(1'b1), .pullup_option_port9_in(1'b1), .pin_in(pin),
    .seg_level_out(seg_level), .seg_drive_en_out(seg_en), .com_level_out(com_level),
    .com_oe_out(com_oe), .drive_phase_out(phase), .bias_current_control_out(bias),
    .port_out_out(port_out), .port_oe_out(port_oe), .pullup_en_out(pullup_en),
    .port_read_out(port_read));

  lcdd_panel panel (.clk_in(clk_in), .clr_in(clr), .seg_level_in(seg_level[1:0]),
    .com_level_in(com_level), .com_oe_in(com_oe), .lit_out(lit), .dc_out(dc));

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rchk

  task automatic wait_rise(input int lim, output int cnt);
    logic prev;
    cnt = 0;
    prev = phase;
    while (cnt < lim && !(prev === 1'b0 && phase === 1'b1))
    begin
      prev = phase;
      @(posedge clk_in);
      #1;
      cnt++;
    end
  endtask : wait_rise

  // timer running, memory filled, mode last
  task automatic run_mode(input logic [7:0] m, input logic [7:0] ram, input logic [3:0] lit_e,
                          input logic [3:0] oe_e, input int per);
    int c;
    for (int a = 8'h58; a <= 8'h7F; a++)
      wr_reg(8'(a), ram);
    wr_reg(`LCDD_MODE_OFS, m);
    wait_rise(5000, c);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    wait_rise(5000, c);
    wait_rise(5000, c);
    chk(16'(c), 16'(per));
    chk(lit, lit_e);
    chk(com_oe, oe_e);
    rchk(8'h58, ram & 8'h0F);
    if (!m[1])
      chk(dc > -200 && dc < 200, 16'h0001);
  endtask : run_mode

  task automatic report_and_stop;
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rchk(`LCDD_MODE_OFS, 8'h00);
    rchk(`LCDD_CTRL_OFS, 8'h00);
    chk(com_oe, 4'hF);
    wr_reg(`LCDD_MODE_OFS, 8'h3C);
    rchk(`LCDD_MODE_OFS, 8'h34);
    wr_reg(`LCDD_CTRL_OFS, 8'hFF);
    rchk(`LCDD_CTRL_OFS, 8'h1F);
    wr_reg(8'h40, 8'hFF);
    rchk(8'h40, 8'h00);
    wr_reg(8'h7F, 8'h0A);
    rchk(8'h7F, 8'h0A);
    // bias current kept on for static drive
    wr_reg(`LCDD_CTRL_OFS, 8'h03);
    repeat (8) @(posedge clk_in);
    #1;
    chk(seg_en, 16'h000F);
    chk(bias, 1'b1);
    chk(port_oe, 16'h00F0);
    chk(port_out & 16'h000F, 16'h0000);
    chk(pullup_en, 16'hFF00);
    chk(port_read, 16'hFFF0);
    @(posedge clk_in);
    pin <= 16'h0000;
    repeat (8) @(posedge clk_in);
    #1;
    chk(port_read, 16'h0000);
    for (int a = 8'h58; a <= 8'h7F; a++)
      wr_reg(8'(a), a[0] ? 8'h0F : 8'h00);
    wr_reg(`LCDD_MODE_OFS, 8'h30);
    repeat (300) @(posedge clk_in);
    #1;
    chk(seg_level === {40{seg_level[1:0]}}, 16'h0001);
    run_mode(8'hB0, 8'h05, 4'h5, 4'hF, 512);
    run_mode(8'hB1, 8'h06, 4'h6, 4'h7, 384);
    run_mode(8'hA3, 8'h03, 4'h3, 4'h7, 768);
    run_mode(8'hB2, 8'h0E, 4'h2, 4'h3, 256);
    run_mode(8'hB4, 8'h01, 4'hF, 4'hF, 128);
    run_mode(8'h94, 8'h01, 4'hF, 4'hF, 512);
    run_mode(8'h84, 8'h01, 4'hF, 4'hF, 1024);
    @(posedge clk_in);
    run <= 1'b0;
    wait_rise(1000, n);
    chk(16'(n), 16'd1000);
    report_and_stop;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      report_and_stop;
    end
  end
endmodule : testbench
